// ---- pcp_edge_div.sv ----
`timescale 1ns/1ps
// Modulo counter that turns an enable stream into a one-cycle carry pulse
module pcp_edge_div
  import pcp_pkg::*;
#(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_en,
  input wire logic i_clr,
  // Carry
  output logic o_tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  if (DIV < 2) begin : g_bad_div
    $error("pcp_edge_div: DIV must be at least 2");
  end

  logic [W-1:0] cnt_ff;
  logic tick_ff;
  wire at_last = (cnt_ff == LAST);
  wire [W-1:0] nxt_cnt = i_clr ? '0 : (!i_en ? cnt_ff :
    (at_last ? '0 : cnt_ff + W'(1)));
  wire nxt_tick = i_en & at_last & ~i_clr;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule // pcp_edge_div

// ---- pcp_periph_model.sv ----
// Peripheral model counting rising edges of its selected clock tap
`timescale 1ns/1ps
module pcp_periph_model (
  // Clock
  input wire logic i_ref_clk,
  // Tap taken from the prescaler
  input wire logic i_tap,
  // Rising edges seen
  output int o_edges
);
  logic tap_ff = 1'b0;
  initial o_edges = 0;
  always @(posedge i_ref_clk) begin
    tap_ff <= i_tap;
    if (i_tap && !tap_ff) o_edges <= o_edges + 1;
  end
endmodule // pcp_periph_model

// ---- pcp_pkg.sv ----
// Package of constants for the peripheral clock prescalers
package pcp_pkg;

  // System-side divider geometry
  localparam int PCP_SYS_WIDTH = 13;
  localparam logic [12:0] PCP_SYS_RESET = 13'h0000;

  // Watch-side divider geometry
  localparam int PCP_WCH_WIDTH = 5;
  localparam logic [4:0] PCP_WCH_RESET = 5'h00;

  // Fixed pre-divide of the watch clock ahead of the watch-side divider
  localparam int PCP_WCH_PREDIV = 4;
  localparam logic [1:0] PCP_WCH_PREDIV_LAST = 2'h3;
  localparam logic [1:0] PCP_WCH_PREDIV_RESET = 2'h0;

  // Oscillator clock divide used in medium-speed mode
  localparam int PCP_MED_DIV = 16;
  localparam logic [3:0] PCP_MED_DIV_LAST = 4'hf;
  localparam logic [3:0] PCP_MED_DIV_RESET = 4'h0;

  // Position of the two clear bits within the timer mode register
  localparam int PCP_TMR_CLR_HI_POS = 3;
  localparam int PCP_TMR_CLR_LO_POS = 2;

  // Operating modes of the device
  typedef enum logic [6:0] {
    PCP_MODE_HIGH = 7'h01,
    PCP_MODE_MED = 7'h02,
    PCP_MODE_SLEEP = 7'h04,
    PCP_MODE_WATCH = 7'h08,
    PCP_MODE_SUBACT = 7'h10,
    PCP_MODE_SUBSLP = 7'h20,
    PCP_MODE_STBY = 7'h40
  } pcp_mode_t;

endpackage

// ---- pcp_prescalers.sv ----
`timescale 1ns/1ps
// Two free-running prescalers supplying clock taps to on-chip peripherals

// Summary of operation
// - 13-bit system divider, one step per clock
// - Reset clears system divider, counts after release
// - Standby, watch, subactive and subsleep modes stop and zero system divider
// - System divider count has no software access
// - Each peripheral picks its own tap
// - Taps: system /2../8192, watch /1../128
// - Medium-speed mode counts oscillator clock over 16
// - 5-bit watch divider after divide-by-four
// - Reset clears watch divider, counts after release
// - Watch divider runs in all low-power modes
// - Both timer clear bits set clear watch divider
// - Watch taps selectable as timebase timer source
module pcp_prescalers
  import pcp_pkg::*;
#(
  parameter int SYS_WIDTH = PCP_SYS_WIDTH,
  parameter int WCH_WIDTH = PCP_WCH_WIDTH,
  parameter int NUM_PERIPH = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Clock enables from the clock pulse generator
  input wire logic i_sys_clk_en,
  input wire logic i_osc_clk_en,
  input wire logic i_watch_clk_en,
  input wire logic i_subclk_present,
  // Operating mode, one-hot
  input wire logic [6:0] i_mode,
  // Write strobe and data of the timebase timer mode register
  input wire logic i_tmr_mode_wr,
  input wire logic [7:0] i_tmr_mode_wdata,
  // Per-peripheral tap selects: 0..12 system /2../8192
  input wire logic [NUM_PERIPH*4-1:0] i_periph_sel,
  // Timebase timer source select: watch tap index 0..7
  input wire logic [2:0] i_tb_sel,
  // Tap outputs
  output logic [SYS_WIDTH-1:0] o_sys_taps,
  output logic [7:0] o_watch_taps,
  output logic [NUM_PERIPH-1:0] o_periph_clk,
  output logic o_tb_clk,
  output logic o_sys_running
);

  // Tap packing assumes the fixed divider widths
  if (SYS_WIDTH != PCP_SYS_WIDTH || WCH_WIDTH != PCP_WCH_WIDTH) begin : g_bad_w
    $error("pcp_prescalers: divider widths are fixed");
  end
  if (NUM_PERIPH < 1) begin : g_bad_np
    $error("pcp_prescalers: NUM_PERIPH must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  wire mode_med = (i_mode == PCP_MODE_MED);
  wire sys_halted = (i_mode == PCP_MODE_STBY) | (i_mode == PCP_MODE_WATCH) |
    (i_mode == PCP_MODE_SUBACT) | (i_mode == PCP_MODE_SUBSLP);

  ////////////////////////////////////////////////////////////////////////////
  // System-side divider

  logic med_tick;

  pcp_edge_div #(
    .DIV(PCP_MED_DIV)
  ) u_med_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_en(i_osc_clk_en),
    .i_clr(~mode_med),
    .o_tick(med_tick)
  );

  // Counter input: oscillator/16 in medium speed, else system clock
  wire sys_step = mode_med ? med_tick : i_sys_clk_en;

  logic [SYS_WIDTH-1:0] sys_cnt_ff;
  // No register path exists to this count
  // Wraps from all ones to zero
  wire [SYS_WIDTH-1:0] nxt_sys_cnt = sys_halted ? PCP_SYS_RESET :
    (sys_step ? sys_cnt_ff + SYS_WIDTH'(1) : sys_cnt_ff);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys_cnt_ff <= PCP_SYS_RESET;
    end else begin
      sys_cnt_ff <= nxt_sys_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watch-side divider

  logic wch_tick;
  // Clear request from the timer mode register
  wire tb_clr = i_tmr_mode_wr & i_tmr_mode_wdata[PCP_TMR_CLR_HI_POS] &
    i_tmr_mode_wdata[PCP_TMR_CLR_LO_POS];

  pcp_edge_div #(
    .DIV(PCP_WCH_PREDIV)
  ) u_wch_prediv (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_en(i_watch_clk_en & i_subclk_present),
    .i_clr(tb_clr),
    .o_tick(wch_tick)
  );

  logic [WCH_WIDTH-1:0] wch_cnt_ff;
  logic [1:0] wch_pre_ff;
  // Runs regardless of mode while subclock is present
  wire [WCH_WIDTH-1:0] nxt_wch_cnt = tb_clr ? PCP_WCH_RESET :
    (wch_tick ? wch_cnt_ff + WCH_WIDTH'(1) : wch_cnt_ff);
  // Mirror of the pre-divide phase for the watch /2 and /4 taps
  wire [1:0] nxt_wch_pre = tb_clr ? PCP_WCH_PREDIV_RESET :
    ((i_watch_clk_en & i_subclk_present) ?
    wch_pre_ff + 2'h1 : wch_pre_ff);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wch_cnt_ff <= PCP_WCH_RESET;
      wch_pre_ff <= PCP_WCH_PREDIV_RESET;
    end else begin
      wch_cnt_ff <= nxt_wch_cnt;
      wch_pre_ff <= nxt_wch_pre;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap selection

  // Watch taps: /2 and /4 from the pre-divide, /8../128 from the counter
  wire [7:0] watch_taps = {wch_cnt_ff, wch_pre_ff, i_watch_clk_en};

  function automatic logic sys_tap_pick(input logic [3:0] sel,
                                        input logic [SYS_WIDTH-1:0] taps);
    logic r;
    r = 1'b0;
    if (sel < 4'(SYS_WIDTH)) begin
      r = taps[sel];
    end
    return r;
  endfunction

  logic [NUM_PERIPH-1:0] periph_clk_ff;
  logic [NUM_PERIPH-1:0] nxt_periph_clk;

  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++) begin : g_periph
      assign nxt_periph_clk[g] =
        sys_tap_pick(i_periph_sel[g*4 +: 4], sys_cnt_ff);
    end
  endgenerate

  wire nxt_tb_clk = watch_taps[i_tb_sel];

  logic [SYS_WIDTH-1:0] sys_taps_ff;
  logic [7:0] watch_taps_ff;
  logic tb_clk_ff;
  logic sys_running_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys_taps_ff <= '0;
      watch_taps_ff <= 8'h00;
      periph_clk_ff <= '0;
      tb_clk_ff <= 1'b0;
      sys_running_ff <= 1'b0;
    end else begin
      sys_taps_ff <= sys_cnt_ff;
      watch_taps_ff <= watch_taps;
      periph_clk_ff <= nxt_periph_clk;
      tb_clk_ff <= nxt_tb_clk;
      sys_running_ff <= ~sys_halted;
    end
  end

  assign o_sys_taps = sys_taps_ff;
  assign o_watch_taps = watch_taps_ff;
  assign o_periph_clk = periph_clk_ff;
  assign o_tb_clk = tb_clk_ff;
  assign o_sys_running = sys_running_ff;

endmodule // pcp_prescalers

// ---- pcp_prescalers_sva.sv ----
// Checker for the peripheral clock prescalers
`timescale 1ns/1ps
module pcp_prescalers_sva
  import pcp_pkg::*;
#(
  parameter int SYS_WIDTH = PCP_SYS_WIDTH,
  parameter int WCH_WIDTH = PCP_WCH_WIDTH,
  parameter int NUM_PERIPH = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Inputs
  input wire logic i_sys_clk_en,
  input wire logic i_osc_clk_en,
  input wire logic i_watch_clk_en,
  input wire logic i_subclk_present,
  input wire logic [6:0] i_mode,
  input wire logic i_tmr_mode_wr,
  input wire logic [7:0] i_tmr_mode_wdata,
  input wire logic [NUM_PERIPH*4-1:0] i_periph_sel,
  input wire logic [2:0] i_tb_sel,
  // Outputs
  input wire logic [SYS_WIDTH-1:0] o_sys_taps,
  input wire logic [7:0] o_watch_taps,
  input wire logic [NUM_PERIPH-1:0] o_periph_clk,
  input wire logic o_tb_clk,
  input wire logic o_sys_running
);
  logic [1:0] up_ff;
  wire ok = (up_ff == 2'h3);
  wire hi = (i_mode == PCP_MODE_HIGH);
  wire md = (i_mode == PCP_MODE_MED);
  wire halt = |(i_mode & 7'h78);
  wire clr = i_tmr_mode_wr & i_tmr_mode_wdata[PCP_TMR_CLR_HI_POS] &
    i_tmr_mode_wdata[PCP_TMR_CLR_LO_POS];
  wire run = i_subclk_present & !clr;
  wire hold = !i_subclk_present & !clr;
  wire [3:0] sel0 = i_periph_sel[3:0];
  wire [6:0] wc = o_watch_taps[7:1];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Cycles since reset, so history is never read from inside reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) up_ff <= 2'h0;
    else if (!ok) up_ff <= up_ff + 2'h1;
  end
  a_sys_count:
  assert property (ok && $past(hi, 2) |-> o_sys_taps ==
    SYS_WIDTH'($past(o_sys_taps) + $past(i_sys_clk_en, 2)))
    else $error("system divider step wrong");
  a_sys_halt:
  assert property (ok && $past(halt, 2) && $past(halt) |-> o_sys_taps == '0)
    else $error("system divider not zero when halted");
  a_sys_run:
  assert property (ok |-> o_sys_running == !$past(halt))
    else $error("running flag wrong");
  a_med_step:
  assert property (ok && $past(md, 2) && $past(md, 3) &&
    !$past(i_osc_clk_en, 3) |-> $stable(o_sys_taps))
    else $error("medium mode stepped without oscillator pulse");
  a_wch_count:
  assert property (ok && $past(run, 2) && !$past(clr, 3) |->
    wc[1:0] == 2'($past(wc[1:0]) + $past(i_watch_clk_en, 2)) &&
    wc[6:2] == 5'($past(wc[6:2]) +
    ($past(wc[1:0], 2) == 2'h3 && $past(wc[1:0]) == 2'h0)))
    else $error("watch divider step wrong");
  a_wch_hold:
  assert property (ok && $past(hold, 2) && $past(hold, 3) |-> $stable(wc))
    else $error("watch divider moved without subclock");
  a_wch_clear:
  assert property (ok && $past(clr, 2) |-> wc == 7'h00)
    else $error("watch divider not cleared");
  a_periph_tap:
  assert property (ok && $past(sel0) < 4'hd |->
    o_periph_clk[0] == o_sys_taps[$past(sel0)])
    else $error("peripheral tap wrong");
  a_tb_tap:
  assert property (ok |-> o_tb_clk == o_watch_taps[$past(i_tb_sel)])
    else $error("timebase tap wrong");
endmodule // pcp_prescalers_sva
bind pcp_prescalers pcp_prescalers_sva #(.SYS_WIDTH(SYS_WIDTH),
  .WCH_WIDTH(WCH_WIDTH), .NUM_PERIPH(NUM_PERIPH)) pcp_prescalers_sva_i (
  .i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n),
  .i_sys_clk_en(i_sys_clk_en),
  .i_osc_clk_en(i_osc_clk_en),
  .i_watch_clk_en(i_watch_clk_en),
  .i_subclk_present(i_subclk_present),
  .i_mode(i_mode),
  .i_tmr_mode_wr(i_tmr_mode_wr),
  .i_tmr_mode_wdata(i_tmr_mode_wdata),
  .i_periph_sel(i_periph_sel),
  .i_tb_sel(i_tb_sel),
  .o_sys_taps(o_sys_taps),
  .o_watch_taps(o_watch_taps),
  .o_periph_clk(o_periph_clk),
  .o_tb_clk(o_tb_clk),
  .o_sys_running(o_sys_running)
);

// ---- tb_top.sv ----
// Testbench for the peripheral clock prescalers
`timescale 1ns/1ps
module tb_top;
  import pcp_pkg::*;
  logic clk = 0, rst_n = 0, sys_en = 1, osc_en = 0, w_en = 1, wr = 0;
  logic sub = 1; // Subclock kept running while timers use it
  logic [6:0] mode = 7'h01;
  logic [7:0] wd = 8'h00;
  logic [15:0] psel = 16'hc300;
  logic [2:0] tsel = 3'h2;
  logic [12:0] st, a;
  logic [7:0] wt;
  logic [3:0] pc;
  logic tb, run;
  int failures = 0, check_count = 0, edges, e0, edges16, e16;
  pcp_prescalers pcp_prescalers_i (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_sys_clk_en(sys_en), .i_osc_clk_en(osc_en), .i_watch_clk_en(w_en),
    .i_subclk_present(sub), .i_mode(mode), .i_tmr_mode_wr(wr),
    .i_tmr_mode_wdata(wd), .i_periph_sel(psel), .i_tb_sel(tsel),
    .o_sys_taps(st), .o_watch_taps(wt), .o_periph_clk(pc), .o_tb_clk(tb),
    .o_sys_running(run));
  pcp_periph_model pcp_periph_model_i (.i_ref_clk(clk), .i_tap(pc[0]),
    .o_edges(edges));
  // Second peripheral on the /16 tap
  pcp_periph_model periph_div16_i (.i_ref_clk(clk), .i_tap(pc[2]),
    .o_edges(edges16));
  initial forever #12.5 clk = ~clk;
  task automatic check(string nm, logic [12:0] seen, logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset();
    cyc(12);
    check("sys in reset", st, 13'h0000);
    check("watch in reset", wt, 13'h0000);
    rst_n = 1;
    cyc(2);
    check("sys after reset", st, 13'h0001);
    check("watch after reset", wt[7:1], 13'h0001);
  endtask
  task automatic t_sys();
    a = st;
    cyc(20);
    check("sys advance", st - a, 13'h0014);
    e0 = edges;
    e16 = edges16;
    cyc(32);
    check("div2 edges", 13'(edges - e0), 13'h0010);
    check("div16 edges", 13'(edges16 - e16), 13'h0002);
    a = st;
    cyc(8192);
    check("sys wrap", st, a);
  endtask
  task automatic t_halt();
    logic [6:0] m[4] = '{7'h08, 7'h10, 7'h20, 7'h40};
    foreach (m[i]) begin
      mode = m[i];
      cyc(3);
      a = wt;
      check("sys halted", st, 13'h0000);
      check("running", run, 13'h0000);
      cyc(4);
      check("watch runs", 7'(wt[7:1] - a[7:1]), 13'h0004);
    end
    // System pulses keep coming and must be ignored in medium speed
    mode = 7'h02;
    cyc(3);
    a = st;
    repeat (64) begin
      osc_en = ~osc_en;
      cyc(1);
    end
    cyc(3);
    check("med rate", st - a, 13'h0002);
    mode = 7'h01;
    osc_en = 0;
  endtask
  task automatic t_watch();
    a = wt;
    wd = 8'h08;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(3);
    check("half clear", wt[7:1], 7'(a[7:1] + 7'h04));
    wd = 8'h0c;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
    check("watch clear", wt[7:1], 13'h0000);
    check("tb tap low", tb, 13'h0000);
    cyc(2);
    check("watch restart", wt[7:1], 13'h0002);
    check("tb tap high", tb, 13'h0001);
    sub = 0;
    cyc(3);
    a = wt;
    cyc(5);
    check("watch frozen", wt[7:1], a[7:1]);
    sub = 1;
  endtask
  initial begin
    t_reset();
    t_sys();
    t_halt();
    t_watch();
    print_verdict();
  end
  initial begin
    #500us;
    failures++;
    print_verdict();
  end
endmodule // tb_top
